// [src/counter_array_defines.svh]
// Register offsets, field positions, reset values and write masks of the counter array.
`ifndef COUNTER_ARRAY_DEFINES_SVH
`define COUNTER_ARRAY_DEFINES_SVH

`define ADDR_MODE_CTRL      8'hD9
`define ADDR_CH0_MODE       8'hDA
`define ADDR_PULSE_CFG      8'hDF
`define ADDR_CNT_LOW        8'hF9
`define ADDR_CNT_HIGH       8'hFA
`define ADDR_CH0_CAP_LOW    8'hFB
`define ADDR_CH0_CAP_HIGH   8'hFC

`define CFG_RELOAD_SEL_BIT  7
`define CFG_WRAP_IE_BIT     6
`define CFG_WRAP_FLAG_BIT   5
`define CFG_LEN_HI          1
`define CFG_LEN_LO          0
`define CFG_WRITE_MASK      8'hE3

`define MODE_WIDE_BIT       7
`define MODE_CMP_EN_BIT     6
`define MODE_TOGGLE_BIT     2
`define MODE_PWM_BIT        1

`define CTRL_WDOG_BIT       6
`define CTRL_RUN_BIT        1
`define CTRL_WRAP_IE_BIT    0
`define CTRL_RESET          8'h40
`define CTRL_WRITE_MASK     8'h43

`define REG_RESET           8'h00
`define CNT_MAX             16'hFFFF
`define CNT_ZERO            16'h0000

`endif

// [src/counter_array_pkg.sv]
// Types shared by the counter array modules.
package counter_array_pkg;

   typedef enum logic [1:0] {
      LEN_8,
      LEN_9,
      LEN_10,
      LEN_11
   } cycle_len_type;

   typedef enum logic [1:0] {
      CH_OFF,
      CH_PWM_SHORT,
      CH_PWM_WIDE,
      CH_FREQ_OUT
   } chan_mode_type;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

endpackage

// [src/cycle_wrap_detect.sv]
// Detects overflow of the bit selected by the cycle length field.
`timescale 1ns/10ps
`include "counter_array_defines.svh"
module cycle_wrap_detect
   import counter_array_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          tick,
   input  wire logic [15:0]   count,
   input  wire cycle_len_type lenSel,
   output logic               wrap
);

   logic [3:0] lowBitsTop;

   always_comb begin
      case (lenSel)
         LEN_8:   lowBitsTop = 4'h7;
         LEN_9:   lowBitsTop = 4'h8;
         LEN_10:  lowBitsTop = 4'h9;
         LEN_11:  lowBitsTop = 4'hA;
         default: lowBitsTop = 4'h7;
      endcase
   end

   always_comb begin
      wrap = 1'b0;
      if (tick) begin
         wrap = 1'b1;
         for (int i = 0; i < 11; i++) begin
            if (i <= int'(lowBitsTop) && !count[i]) begin
               wrap = 1'b0;
            end
         end
      end
   end

endmodule

// [src/channel0_decode.sv]
// Decodes the channel 0 mode register into an operating mode.
`timescale 1ns/10ps
`include "counter_array_defines.svh"
module channel0_decode
   import counter_array_pkg::*;
(
   input  wire logic [7:0]    modeReg,
   output chan_mode_type      chanMode
);

   always_comb begin
      chanMode = CH_OFF;
      if (modeReg[`MODE_PWM_BIT] && modeReg[`MODE_TOGGLE_BIT]) begin
         chanMode = CH_FREQ_OUT;
      end else if (modeReg[`MODE_PWM_BIT] && modeReg[`MODE_WIDE_BIT]) begin
         chanMode = CH_PWM_WIDE;
      end else if (modeReg[`MODE_PWM_BIT]) begin
         chanMode = CH_PWM_SHORT;
      end
   end

endmodule

// [src/counter_array_pwm_config.sv]
// Counter array timer, shared PWM cycle configuration and channel 0 registers.
`timescale 1ns/10ps
`include "counter_array_defines.svh"
module counter_array_pwm_config
   import counter_array_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          sfrWrite,
   input  wire logic          sfrRead,
   input  wire logic [7:0]    sfrAddr,
   input  wire logic [7:0]    sfrWdata,
   input  wire logic          countTick,
   output logic [7:0]         sfrRdata,
   output logic               irqReq,
   output logic               pwmOut,
   output chan_mode_type      chanMode
);

   ////////////////////////////////////////////////////////////////////////
   sfr_req_type   req;
   logic [7:0]    ctrl_q;
   logic [7:0]    cfg_q;
   logic [7:0]    chMode_q;
   logic [15:0]   count_q;
   logic [7:0]    snapHigh_q;
   logic [15:0]   capture_q;
   logic [15:0]   reload_q;
   logic          counterWrap_q;
   logic          cycleWrap;
   logic          tick;
   logic          counterWrap;
   logic          wdogOn;
   logic          reloadSel;
   logic          shortPwm;
   logic [10:0]   lenMask;
   logic [7:0]    sfrRdata_d;
   logic          pwmOut_d;

   assign req       = '{write: sfrWrite, read: sfrRead, addr: sfrAddr, wdata: sfrWdata};
   assign wdogOn    = ctrl_q[`CTRL_WDOG_BIT];
   assign reloadSel = cfg_q[`CFG_RELOAD_SEL_BIT];
   assign tick      = countTick && ctrl_q[`CTRL_RUN_BIT];

   function automatic logic hit(input sfr_req_type r, input logic [7:0] a);
      hit = r.write && (r.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Mode and control registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
      end else if (hit(req, `ADDR_MODE_CTRL)) begin
         ctrl_q <= req.wdata & `CTRL_WRITE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chMode_q <= `REG_RESET;
      end else if (hit(req, `ADDR_CH0_MODE)) begin
         chMode_q <= req.wdata;
      end else if (hit(req, `ADDR_CH0_CAP_LOW) && !reloadSel) begin
         chMode_q[`MODE_CMP_EN_BIT] <= 1'b0;
      end
   end

   channel0_decode u_decode (
      .modeReg  (chMode_q),
      .chanMode (chanMode)
   );

   ////////////////////////////////////////////////////////////////////////
   // PWM configuration register.
   cycle_wrap_detect u_wrap (
      .clk    (clk),
      .rst    (rst),
      .tick   (tick),
      .count  (count_q),
      .lenSel (cycle_len_type'(cfg_q[`CFG_LEN_HI:`CFG_LEN_LO])),
      .wrap   (cycleWrap)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q <= `REG_RESET;
      end else begin
         if (hit(req, `ADDR_PULSE_CFG)) begin
            cfg_q <= req.wdata & `CFG_WRITE_MASK;
         end
         if (cycleWrap) begin
            cfg_q[`CFG_WRAP_FLAG_BIT] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter, overflow flag and snapshot.
   assign counterWrap = tick && (count_q == `CNT_MAX);

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= `CNT_ZERO;
      end else if (hit(req, `ADDR_CNT_LOW) && !wdogOn) begin
         count_q[7:0] <= req.wdata;
      end else if (hit(req, `ADDR_CNT_HIGH) && !wdogOn) begin
         count_q[15:8] <= req.wdata;
      end else if (tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         counterWrap_q <= 1'b0;
      end else if (counterWrap) begin
         counterWrap_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         snapHigh_q <= `REG_RESET;
      end else if (req.read && req.addr == `ADDR_CNT_LOW) begin
         snapHigh_q <= count_q[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture/compare and auto-reload banks.
   assign shortPwm = (chanMode == CH_PWM_SHORT) &&
                     (cfg_q[`CFG_LEN_HI:`CFG_LEN_LO] != 2'b00);

   always_ff @(posedge clk) begin
      if (rst) begin
         reload_q <= `CNT_ZERO;
      end else if (reloadSel && hit(req, `ADDR_CH0_CAP_LOW)) begin
         reload_q[7:0] <= req.wdata;
      end else if (reloadSel && hit(req, `ADDR_CH0_CAP_HIGH)) begin
         reload_q[15:8] <= req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         capture_q <= `CNT_ZERO;
      end else if (!reloadSel && hit(req, `ADDR_CH0_CAP_LOW)) begin
         capture_q[7:0] <= req.wdata;
      end else if (!reloadSel && hit(req, `ADDR_CH0_CAP_HIGH)) begin
         capture_q[15:8] <= req.wdata;
      end else if (cycleWrap && shortPwm) begin
         capture_q <= reload_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel 0 PWM output.
   // Length field to mask.
   always_comb begin
      case (cfg_q[`CFG_LEN_HI:`CFG_LEN_LO])
         2'b00:   lenMask = 11'h0FF;
         2'b01:   lenMask = 11'h1FF;
         2'b10:   lenMask = 11'h3FF;
         2'b11:   lenMask = 11'h7FF;
         default: lenMask = 11'h0FF;
      endcase
   end

   always_comb begin
      pwmOut_d = 1'b0;
      case (chanMode)
         CH_PWM_SHORT: pwmOut_d = (count_q[10:0] & lenMask) >= (capture_q[10:0] & lenMask);
         CH_PWM_WIDE:  pwmOut_d = count_q >= capture_q;
         CH_FREQ_OUT:  pwmOut_d = pwmOut ^ (tick && count_q[7:0] == capture_q[15:8]);
         default:      pwmOut_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pwmOut <= 1'b0;
      end else begin
         pwmOut <= pwmOut_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and interrupt.
   always_comb begin
      case (req.addr)
         `ADDR_MODE_CTRL:    sfrRdata_d = ctrl_q;
         `ADDR_CH0_MODE:     sfrRdata_d = chMode_q;
         `ADDR_PULSE_CFG:    sfrRdata_d = cfg_q;
         `ADDR_CNT_LOW:      sfrRdata_d = count_q[7:0];
         `ADDR_CNT_HIGH:     sfrRdata_d = snapHigh_q;
         `ADDR_CH0_CAP_LOW:  sfrRdata_d = reloadSel ? reload_q[7:0] : capture_q[7:0];
         `ADDR_CH0_CAP_HIGH: sfrRdata_d = reloadSel ? reload_q[15:8] : capture_q[15:8];
         default:            sfrRdata_d = `REG_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sfrRdata <= `REG_RESET;
      end else if (req.read) begin
         sfrRdata <= sfrRdata_d;
      end
   end

   assign irqReq = (cfg_q[`CFG_WRAP_IE_BIT] && cfg_q[`CFG_WRAP_FLAG_BIT]) ||
                   (ctrl_q[`CTRL_WRAP_IE_BIT] && counterWrap_q);

endmodule

// [dv/counter_array_pwm_config_monitor.sv]
// Port-level checker of the counter array configuration block.
`timescale 1ns/10ps
`include "counter_array_defines.svh"
module counter_array_pwm_config_monitor
   import counter_array_pkg::*;
(
   input wire logic          clk,
   input wire logic          rst,
   input wire logic          sfrWrite,
   input wire logic          sfrRead,
   input wire logic [7:0]    sfrAddr,
   input wire logic [7:0]    sfrWdata,
   input wire logic          countTick,
   input wire logic [7:0]    sfrRdata,
   input wire logic          irqReq,
   input wire logic          pwmOut,
   input wire chan_mode_type chanMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire cfgW  = sfrWrite && sfrAddr == `ADDR_PULSE_CFG;
   wire cfgR  = sfrRead && sfrAddr == `ADDR_PULSE_CFG;
   wire modeW = sfrWrite && sfrAddr == `ADDR_CH0_MODE;
   ////////////////////////////////////////////////////////////////////////
   property p_reserved; cfgR |=> sfrRdata[4:2] == 3'h0; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
   property p_irq_on; cfgW && sfrWdata[6] && sfrWdata[5] |=> irqReq; endproperty
   a_irq_on: assert property (p_irq_on) else $error("enabled flag gave no irq");
   property p_irq_reset; $past(rst) |-> !irqReq; endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("irq after reset");
   property p_flag_set; cfgW && sfrWdata[5] ##1 !cfgW ##1 cfgR |=> sfrRdata[5]; endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag write lost");
   property p_len;
      cfgW ##2 cfgR |=> (sfrRdata & 8'hC3) == ($past(sfrWdata, 3) & 8'hC3);
   endproperty
   a_len: assert property (p_len) else $error("config readback wrong");
   property p_hold; !$past(sfrRead) |-> $stable(sfrRdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_freq; modeW && sfrWdata[2:1] == 2'h3 |=> chanMode == CH_FREQ_OUT; endproperty
   a_freq: assert property (p_freq) else $error("no frequency mode");
   property p_wide;
      modeW && sfrWdata[7] && sfrWdata[2:1] == 2'h1 |=> chanMode == CH_PWM_WIDE;
   endproperty
   a_wide: assert property (p_wide) else $error("no wide mode");
endmodule
bind counter_array_pwm_config counter_array_pwm_config_monitor counter_array_pwm_config_monitor_i (
   .clk       (clk),
   .rst       (rst),
   .sfrWrite  (sfrWrite),
   .sfrRead   (sfrRead),
   .sfrAddr   (sfrAddr),
   .sfrWdata  (sfrWdata),
   .countTick (countTick),
   .sfrRdata  (sfrRdata),
   .irqReq    (irqReq),
   .pwmOut    (pwmOut),
   .chanMode  (chanMode)
);

// [dv/counter_array_pwm_config_tb.sv]
// Self-checking bench with a register model of the counter array.
`timescale 1ns/10ps
module counter_array_pwm_config_tb;
   import counter_array_pkg::*;
   logic clk = 0, rst = 1, sfrWrite = 0, sfrRead = 0, countTick = 0;
   logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
   logic irqReq, pwmOut;
   chan_mode_type chanMode;
   int n_mismatch = 0, checked = 0, cyc = 0, mCnt = 0, mCfg = 0, mCtrl = 8'h40, mSnap = 0, mMode = 0;
   int mCap = 0, mRel = 0;
   bit mWrap = 0;
   logic [31:0] seed = 32'hCFC2, v;
   always #2 clk = ~clk;
   counter_array_pwm_config counter_array_pwm_config_i (.clk(clk), .rst(rst), .sfrWrite(sfrWrite),
      .sfrRead(sfrRead), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .countTick(countTick),
      .sfrRdata(sfrRdata), .irqReq(irqReq), .pwmOut(pwmOut), .chanMode(chanMode));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nextRnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic bit expPwm();
      int m;
      m = (256 << mCfg[1:0]) - 1;
      if (!mMode[1]) return 0;
      if (mMode[7]) return mCnt >= mCap;
      return (mCnt & m) >= (mCap & m);
   endfunction
   task final_report();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cmpByte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task cmpBit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {sfrWrite, sfrAddr, sfrWdata} = {1'b1, a, d};
      @(negedge clk);
      sfrWrite = 0;
      case (a)
         8'hD9: mCtrl = d & 8'h43;
         8'hDA: mMode = d;
         8'hDF: mCfg = d & 8'hE3;
         8'hF9: if (!mCtrl[6]) mCnt[7:0] = d;
         8'hFA: if (!mCtrl[6]) mCnt[15:8] = d;
         8'hFB: begin
            if (mCfg[7]) begin
               mRel[7:0] = d;
            end else begin
               mCap[7:0] = d;
               mMode[6] = 0;
            end
         end
         8'hFC: begin
            if (mCfg[7]) begin
               mRel[15:8] = d;
            end else begin
               mCap[15:8] = d;
            end
         end
         default: ;
      endcase
   endtask
   task rd(input logic [7:0] a);
      logic [7:0] exp;
      exp = a == 8'hD9 ? mCtrl : a == 8'hDA ? mMode : a == 8'hDF ? mCfg :
            a == 8'hF9 ? mCnt[7:0] : a == 8'hFA ? mSnap : 8'h00;
      if (a == 8'hFB) exp = mCfg[7] ? mRel[7:0] : mCap[7:0];
      if (a == 8'hFC) exp = mCfg[7] ? mRel[15:8] : mCap[15:8];
      @(negedge clk);
      {sfrRead, sfrAddr} = {1'b1, a};
      @(negedge clk);
      sfrRead = 0;
      if (a == 8'hF9) mSnap = mCnt[15:8];
      cmpByte(sfrRdata, exp);
      cmpBit(irqReq, (mCfg[6] & mCfg[5]) | (mCtrl[0] & mWrap));
   endtask
   task tick(input int n);
      repeat (n) begin
         @(negedge clk);
         countTick = 1;
         @(negedge clk);
         countTick = 0;
         if (mCtrl[1]) begin
            mCnt = (mCnt + 1) & 16'hFFFF;
            if ((mCnt & ((256 << mCfg[1:0]) - 1)) == 0) begin
               mCfg |= 8'h20;
               if (mMode[2:1] == 2'h1 && !mMode[7] && mCfg[1:0] != 0) mCap = mRel;
            end
            if (mCnt == 0) mWrap = 1;
         end
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 6000) begin
         n_mismatch++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 0;
      for (int i = 0; i < 6; i++) rd(i == 0 ? 8'hD9 : i == 1 ? 8'hDA : i == 2 ? 8'hDF :
                                     i == 3 ? 8'hF9 : i == 4 ? 8'hFA : 8'h5A);
      $display("test reset done");
      wr(8'hF9, 8'h55);
      wr(8'hFA, 8'h66);
      rd(8'hF9);
      rd(8'hFA);
      wr(8'hD9, 8'h00);
      repeat (4) begin
         v = nextRnd();
         wr(8'hF9, v[7:0]);
         wr(8'hFA, v[15:8]);
         rd(8'hF9);
         wr(8'hFA, v[23:16]);
         rd(8'hFA);
         rd(8'hF9);
         rd(8'hFA);
      end
      $display("test counter access done");
      repeat (6) begin
         v = nextRnd();
         wr(8'hDF, v[7:0] & 8'hE3);
         rd(8'hDF);
         wr(8'hFB, v[15:8]);
         wr(8'hFC, v[23:16]);
         rd(8'hFB);
         rd(8'hFC);
         wr(8'hDF, (v[7:0] ^ 8'h80) & 8'hE3);
         rd(8'hFB);
         rd(8'hFC);
      end
      $display("test config done");
      for (int len = 0; len < 4; len++) begin
         wr(8'hD9, 8'h00);
         wr(8'hDF, 8'h40 | len);
         wr(8'hFA, ((256 << len) - 2) >> 8);
         wr(8'hF9, 8'hFE);
         wr(8'hD9, 8'h02);
         tick(1);
         rd(8'hDF);
         tick(1);
         rd(8'hDF);
         tick(3);
         rd(8'hDF);
         wr(8'hDF, len);
         rd(8'hDF);
      end
      $display("test cycle wrap done");
      wr(8'hD9, 8'h00);
      wr(8'hFA, 8'hFF);
      wr(8'hF9, 8'hFE);
      wr(8'hD9, 8'h03);
      tick(2);
      rd(8'hF9);
      rd(8'hDF);
      wr(8'hD9, 8'h02);
      rd(8'hD9);
      $display("test counter wrap done");
      for (int i = 0; i < 9; i++) begin
         v = i < 5 ? {24'h0, i == 0 ? 8'h06 : i == 1 ? 8'h82 : i == 2 ? 8'h02 : i == 3 ? 8'h04 : 8'h86}
                   : nextRnd();
         wr(8'hDA, v[7:0]);
         cmpByte({6'h00, chanMode}, v[2:1] == 2'h3 ? 8'h03 : v[1] ? (v[7] ? 8'h02 : 8'h01) : 8'h00);
         rd(8'hDA);
      end
      $display("test channel mode done");
      wr(8'hD9, 8'h00);
      for (int len = 0; len < 2; len++) begin
         wr(8'hDA, 8'h42);
         wr(8'hDF, 8'h80);
         wr(8'hFB, 8'h80);
         wr(8'hFC, 8'h00);
         wr(8'hDF, len);
         wr(8'hFB, 8'h40);
         wr(8'hFC, 8'h00);
         rd(8'hDA);
         wr(8'hFA, ((256 << len) - 1) >> 8);
         wr(8'hF9, 8'hFF);
         wr(8'hD9, 8'h02);
         tick(1);
         rd(8'hFB);
         cmpBit(pwmOut, expPwm());
      end
      wr(8'hDA, 8'h82);
      rd(8'hDA);
      cmpBit(pwmOut, expPwm());
      wr(8'hDA, 8'h02);
      wr(8'hDF, 8'h02);
      rd(8'hDF);
      cmpBit(pwmOut, expPwm());
      wr(8'hDF, 8'h00);
      rd(8'hDF);
      cmpBit(pwmOut, expPwm());
      $display("test reload and pwm done");
      final_report();
   end
endmodule
